//--- rtl/cwstk_pkg.sv
// Constants, register map and timing for the CW sidetone and keying block
package cwstk_pkg;

	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int CLK_MHZ = 200;
	localparam int RX_DELAY_MS = 10;
	localparam int RX_DELAY_CYC = RX_DELAY_MS * CLK_MHZ * 1000;
	localparam int LCD_SETUP_NS = 40;
	localparam int LCD_PULSE_NS = 230;
	localparam int LCD_HOLD_NS = 270;
	// Least times round up
	localparam int LCD_SETUP_CYC = (LCD_SETUP_NS * CLK_MHZ + 999) / 1000;
	localparam int LCD_PULSE_CYC = (LCD_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int LCD_HOLD_CYC = (LCD_HOLD_NS * CLK_MHZ + 999) / 1000;

	// ----------------------------------------
	// Sidetone
	// ----------------------------------------
	localparam int CARRIERS_PER_TONE = 60;
	localparam int CARRIERS_PER_HALF = CARRIERS_PER_TONE / 2;

	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CARRIER = 8'h04;
	localparam logic [7:0] REG_DEVIATION = 8'h08;
	localparam logic [7:0] REG_AUTO_KEY = 8'h0c;
	localparam logic [7:0] REG_DISPLAY = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;

	// Field positions
	localparam int CTRL_AUTO_BIT = 0;
	localparam int CTRL_BACKLIGHT_BIT = 1;
	localparam int DISP_RS_BIT = 8;
	localparam int STAT_KEY_BIT = 0;
	localparam int STAT_RX_BIT = 1;
	localparam int STAT_DISP_BUSY_BIT = 2;
	localparam int STAT_AUTO_BUSY_BIT = 3;
	localparam int STAT_PHASE_BIT = 4;

	// Reset values: 700 Hz tone gives 4762 clocks per carrier period
	localparam logic [15:0] CARRIER_RST = 16'h129a;
	localparam logic [15:0] DEVIATION_RST = 16'h002f;
	localparam logic [1:0] CTRL_RST = 2'h0;

	typedef enum logic {
		CWSTK_STRAIGHT,
		CWSTK_AUTO
	} cwstk_mode_t;

endpackage

//--- rtl/cwstk_top.sv
// Sidetone PWM, keying, receive enable and write-only display port
//
// Chosen here: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
module cwstk_top #(
	parameter int RX_DELAY = cwstk_pkg::RX_DELAY_CYC,
	parameter int CW = 16,
	parameter int AW = 24
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Key and radio control
	input wire logic key_i,
	output logic key_o,
	output logic rx_en_o,
	output logic tone_o,
	// Display
	output logic [3:0] lcd_d_o,
	output logic lcd_rs_o,
	output logic lcd_e_o
);
	import cwstk_pkg::*;

	typedef enum {
		CWSTK_IDLE,
		CWSTK_SETUP,
		CWSTK_PULSE,
		CWSTK_HOLD
	} cwstk_lcd_t;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic ack_ff;
	logic [31:0] rdat_ff;
	logic [1:0] ctrl_ff;
	logic [CW-1:0] carrier_ff;
	logic [CW-1:0] dev_ff;
	logic [AW-1:0] auto_ff;
	logic key_ff;
	logic [31:0] rx_cnt_ff;
	logic [CW-1:0] car_cnt_ff;
	logic [5:0] per_cnt_ff;
	logic phase_ff;
	logic tone_ff;
	cwstk_lcd_t lcd_st_ff;
	logic [7:0] lcd_byte_ff;
	logic lcd_rs_ff;
	logic lcd_lo_ff;
	logic [7:0] lcd_cnt_ff;
	logic [3:0] lcd_d_ff;
	logic lcd_e_ff;
	logic wr_req;
	logic rd_req;
	logic car_wrap;
	logic lcd_busy;
	logic [CW-1:0] half;
	logic [CW-1:0] dev_lim;
	logic [CW-1:0] high_up;
	logic [CW-1:0] high_dn;
	logic [CW-1:0] nxt_high;
	logic nxt_key;

	assign wr_req = cyc_i && stb_i && !ack_ff && we_i;
	assign rd_req = cyc_i && stb_i && !ack_ff && !we_i;
	assign lcd_busy = lcd_st_ff != CWSTK_IDLE;

	// ----------------------------------------
	// Wishbone slave
	// ----------------------------------------
	// One wait state; unmapped addresses ack with zero and ignore writes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= cyc_i && stb_i && !ack_ff;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdat_ff <= 32'h0;
		end else if (rd_req) begin
			rdat_ff <= 32'h0;
			unique case (adr_i)
				REG_CTRL: rdat_ff[1:0] <= ctrl_ff;
				REG_CARRIER: rdat_ff[CW-1:0] <= carrier_ff;
				REG_DEVIATION: rdat_ff[CW-1:0] <= dev_ff;
				REG_AUTO_KEY: rdat_ff[AW-1:0] <= auto_ff;
				REG_STATUS: begin
					rdat_ff[STAT_KEY_BIT] <= key_ff;
					rdat_ff[STAT_RX_BIT] <= rx_en_o;
					rdat_ff[STAT_DISP_BUSY_BIT] <= lcd_busy;
					rdat_ff[STAT_AUTO_BUSY_BIT] <= auto_ff != '0;
					rdat_ff[STAT_PHASE_BIT] <= phase_ff;
				end
				default: rdat_ff <= 32'h0;
			endcase
		end
	end

	assign ack_o = ack_ff;
	assign dat_o = rdat_ff;

	// Settings software can change
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_ff <= CTRL_RST;
			carrier_ff <= CARRIER_RST;
			dev_ff <= DEVIATION_RST;
		end else if (wr_req) begin
			if (adr_i == REG_CTRL && sel_i[0]) begin
				ctrl_ff <= dat_i[1:0];
			end
			if (adr_i == REG_CARRIER) begin
				if (sel_i[0]) carrier_ff[7:0] <= dat_i[7:0];
				if (sel_i[1]) carrier_ff[15:8] <= dat_i[15:8];
			end
			if (adr_i == REG_DEVIATION) begin
				if (sel_i[0]) dev_ff[7:0] <= dat_i[7:0];
				if (sel_i[1]) dev_ff[15:8] <= dat_i[15:8];
			end
		end
	end

	// ----------------------------------------
	// Keying
	// ----------------------------------------
	// Auto key-down length in clocks; a write starts it, key-up at zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			auto_ff <= '0;
		end else if (wr_req && adr_i == REG_AUTO_KEY && ctrl_ff[CTRL_AUTO_BIT]) begin
			auto_ff <= dat_i[AW-1:0];
		end else if (!ctrl_ff[CTRL_AUTO_BIT]) begin
			auto_ff <= '0;
		end else if (auto_ff != '0) begin
			auto_ff <= auto_ff - 1'b1;
		end
	end

	always_comb begin
		if (ctrl_ff[CTRL_AUTO_BIT] == CWSTK_AUTO) begin
			nxt_key = auto_ff != '0;
		end else begin
			nxt_key = key_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			key_ff <= 1'b0;
		end else begin
			key_ff <= nxt_key;
		end
	end

	assign key_o = key_ff;

	// Receive waits out the envelope fall before reopening the mixer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_cnt_ff <= 32'h0;
		end else if (key_ff) begin
			rx_cnt_ff <= 32'(RX_DELAY);
		end else if (rx_cnt_ff != 32'h0) begin
			rx_cnt_ff <= rx_cnt_ff - 32'h1;
		end
	end

	assign rx_en_o = !key_ff && rx_cnt_ff == 32'h0;

	// ----------------------------------------
	// Sidetone
	// ----------------------------------------
	// Carrier period = clk / (60 x tone), so swapping every 30 gives the tone
	assign half = carrier_ff >> 1;
	assign dev_lim = (dev_ff >= half) ? half - 1'b1 : dev_ff;
	assign high_up = half + dev_lim;
	assign high_dn = half - dev_lim;
	assign nxt_high = phase_ff ? high_up : high_dn;
	assign car_wrap = car_cnt_ff >= carrier_ff - 1'b1;

	always_ff @(posedge clk_i) begin
		if (rst_i || !key_ff) begin
			car_cnt_ff <= '0;
		end else if (car_wrap) begin
			car_cnt_ff <= '0;
		end else begin
			car_cnt_ff <= car_cnt_ff + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || !key_ff) begin
			per_cnt_ff <= 6'h0;
			phase_ff <= 1'b1;
		end else if (car_wrap) begin
			if (per_cnt_ff == 6'(CARRIERS_PER_HALF - 1)) begin
				per_cnt_ff <= 6'h0;
				phase_ff <= !phase_ff;
			end else begin
				per_cnt_ff <= per_cnt_ff + 6'h1;
			end
		end
	end

	// Idle low; off-air the audio path is muted anyway
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tone_ff <= 1'b0;
		end else begin
			tone_ff <= key_ff && car_cnt_ff < nxt_high;
		end
	end

	assign tone_o = tone_ff;

	// ----------------------------------------
	// Display write port
	// ----------------------------------------
	// Write-only: no read strobe exists, the display's select is grounded
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lcd_st_ff <= CWSTK_IDLE;
			lcd_byte_ff <= 8'h0;
			lcd_rs_ff <= 1'b0;
			lcd_lo_ff <= 1'b0;
			lcd_cnt_ff <= 8'h0;
		end else begin
			unique case (lcd_st_ff)
				CWSTK_IDLE: begin
					// Writes while busy are dropped; poll the busy bit first
					if (wr_req && adr_i == REG_DISPLAY && sel_i[0]) begin
						lcd_byte_ff <= dat_i[7:0];
						lcd_rs_ff <= dat_i[DISP_RS_BIT];
						lcd_lo_ff <= 1'b0;
						lcd_cnt_ff <= 8'(LCD_SETUP_CYC - 1);
						lcd_st_ff <= CWSTK_SETUP;
					end
				end
				CWSTK_SETUP: begin
					if (lcd_cnt_ff == 8'h0) begin
						lcd_cnt_ff <= 8'(LCD_PULSE_CYC - 1);
						lcd_st_ff <= CWSTK_PULSE;
					end else begin
						lcd_cnt_ff <= lcd_cnt_ff - 8'h1;
					end
				end
				CWSTK_PULSE: begin
					if (lcd_cnt_ff == 8'h0) begin
						lcd_cnt_ff <= 8'(LCD_HOLD_CYC - 1);
						lcd_st_ff <= CWSTK_HOLD;
					end else begin
						lcd_cnt_ff <= lcd_cnt_ff - 8'h1;
					end
				end
				CWSTK_HOLD: begin
					if (lcd_cnt_ff != 8'h0) begin
						lcd_cnt_ff <= lcd_cnt_ff - 8'h1;
					end else if (!lcd_lo_ff) begin
						lcd_lo_ff <= 1'b1;
						lcd_cnt_ff <= 8'(LCD_SETUP_CYC - 1);
						lcd_st_ff <= CWSTK_SETUP;
					end else begin
						lcd_st_ff <= CWSTK_IDLE;
					end
				end
			endcase
		end
	end

	// Upper nibble first; bit 3 rests at the backlight level
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lcd_d_ff <= 4'h0;
			lcd_e_ff <= 1'b0;
		end else begin
			lcd_e_ff <= lcd_st_ff == CWSTK_PULSE;
			if (lcd_st_ff == CWSTK_IDLE) begin
				lcd_d_ff <= {ctrl_ff[CTRL_BACKLIGHT_BIT], 3'h0};
			end else begin
				lcd_d_ff <= lcd_lo_ff ? lcd_byte_ff[3:0] : lcd_byte_ff[7:4];
			end
		end
	end

	assign lcd_d_o = lcd_d_ff;
	assign lcd_rs_o = lcd_rs_ff;
	assign lcd_e_o = lcd_e_ff;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	logic [9:0] burst_cnt_ff;
	always_ff @(posedge clk_i) begin
		if (rst_i || !lcd_busy) begin
			burst_cnt_ff <= 10'h0;
		end else if (burst_cnt_ff != 10'h3ff) begin
			burst_cnt_ff <= burst_cnt_ff + 10'h1;
		end
	end

	sequence s_key_fall;
		$fell(key_o);
	endsequence
	sequence s_rx_held;
		!rx_en_o [*8];
	endsequence

	a_straight_copy: assert property (@(posedge clk_i) disable iff (rst_i)
		!ctrl_ff[CTRL_AUTO_BIT] && $past(!ctrl_ff[CTRL_AUTO_BIT]) |-> key_o == $past(key_i))
		else $error("straight key not copied");
	a_rx_key_low: assert property (@(posedge clk_i) disable iff (rst_i)
		key_o |-> !rx_en_o)
		else $error("receive enabled during key-down");
	a_rx_hold_off: assert property (@(posedge clk_i) disable iff (rst_i)
		s_key_fall |-> s_rx_held)
		else $error("receive returned too soon after key-up");
	a_tone_keyed: assert property (@(posedge clk_i) disable iff (rst_i)
		tone_o |-> $past(key_o))
		else $error("sidetone without key-down");
	a_duty_sym: assert property (@(posedge clk_i) disable iff (rst_i)
		high_up + high_dn == {half[CW-2:0], 1'b0})
		else $error("duty deviation not symmetric");
	a_phase_swap: assert property (@(posedge clk_i) disable iff (rst_i)
		key_ff && $past(key_ff) && phase_ff != $past(phase_ff) |->
		$past(car_wrap) && $past(per_cnt_ff) == 6'(CARRIERS_PER_HALF - 1))
		else $error("duty swapped off the thirty-period mark");
	a_backlight_rest: assert property (@(posedge clk_i) disable iff (rst_i)
		!lcd_busy && $past(!lcd_busy) && $past(lcd_st_ff == CWSTK_IDLE)
		|-> lcd_d_o[3] == $past(ctrl_ff[CTRL_BACKLIGHT_BIT]))
		else $error("backlight level not held between bursts");
	a_burst_short: assert property (@(posedge clk_i) disable iff (rst_i)
		burst_cnt_ff < 10'h258)
		else $error("display burst too long");
	a_bus_ack: assert property (@(posedge clk_i) disable iff (rst_i)
		cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
		else $error("bus answer not one cycle");

endmodule

//--- verification/cwstk_lcd_model.sv
// Display model that captures nibbles written over the four-bit port
`timescale 1ns/1ps
module cwstk_lcd_model (
	// Display pins
	input wire logic clk_i,
	input wire logic [3:0] lcd_d_i,
	input wire logic rs_i,
	input wire logic e_i,
	// Captured traffic
	output logic [7:0] byte_o,
	output logic rs_o,
	output logic [7:0] nib_o
);
	logic e_ff;
	initial begin
		nib_o = 8'h00;
		byte_o = 8'h00;
		rs_o = 1'b0;
		e_ff = 1'b0;
	end
	// ----------------------------------------
	// Capture
	// ----------------------------------------
	// No read strobe exists, so every cycle is a write
	always @(posedge clk_i) begin
		e_ff <= e_i;
		// Latch on the falling strobe, high nibble first
		if (e_ff && !e_i) begin
			byte_o <= {byte_o[3:0], lcd_d_i};
			rs_o <= rs_i;
			nib_o <= nib_o + 8'h01;
		end
	end
endmodule

//--- verification/test_cwstk_top.sv
// Self-checking bench for the sidetone, keying and display block
`timescale 1ns/1ps
module test_cwstk_top;
	import cwstk_pkg::*;
	localparam int RXD = 50;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, key = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0, dat_o, q;
	logic ack_o, key_o, rx_en_o, tone_o, lcd_rs_o, lcd_e_o, m_rs;
	logic [3:0] lcd_d_o;
	logic [7:0] m_byte, m_nib;
	int n_errors = 0, checks_done = 0, cnt, t0;
	always #2.5 clk_i = ~clk_i;
	cwstk_top #(.RX_DELAY(RXD)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(4'hf), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .key_i(key), .key_o(key_o),
		.rx_en_o(rx_en_o), .tone_o(tone_o), .lcd_d_o(lcd_d_o), .lcd_rs_o(lcd_rs_o), .lcd_e_o(lcd_e_o));
	cwstk_lcd_model u_lcd (.clk_i(clk_i), .lcd_d_i(lcd_d_o), .rs_i(lcd_rs_o), .e_i(lcd_e_o),
		.byte_o(m_byte), .rs_o(m_rs), .nib_o(m_nib));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task end_of_test;
		$display("errors=%0d checks=%0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
			n_errors++;
		end
	endtask
	// Classic cycle: hold until ack is sampled, then release
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		{cyc, stb, we, adr, dat} <= {1'b1, 1'b1, w, a, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		if (n >= 50) begin
			chk(32'h1, 32'h0);
			end_of_test();
		end
		q = dat_o;
		{cyc, stb} <= 2'b00;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	task wait_tone(input logic v);
		int n;
		n = 0;
		while (tone_o !== v && n < 2000) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 2000) begin
			chk(32'h1, 32'h0);
			end_of_test();
		end
	endtask
	// Carrier of 20 clocks: half is 10
	task tone_run(input int dv);
		int nhi, nlo, sum, tot, nl;
		{nhi, nlo, sum, tot} = 0;
		wb(1'b1, REG_DEVIATION, 32'(dv));
		key <= 1'b1;
		wait_tone(1'b0);
		wait_tone(1'b1);
		for (int i = 0; i < 60; i++) begin
			cnt = 0;
			nl = 0;
			while (tone_o === 1'b1 && cnt < 100) begin
				@(posedge clk_i);
				cnt++;
			end
			// Low time is measured too, so the period check sees real edges
			while (tone_o === 1'b0 && nl < 100) begin
				@(posedge clk_i);
				nl++;
			end
			if (cnt >= 100 || nl >= 100) begin
				chk(32'h1, 32'h0);
				end_of_test();
			end
			nhi += (cnt == 10 + dv);
			nlo += (cnt == 10 - dv);
			sum += cnt;
			tot += cnt + nl;
		end
		chk(nhi, 30);
		chk(nlo, 30);
		chk(sum, 600);
		chk(tot, 1200);
		key <= 1'b0;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(REG_CARRIER, 32'h129a);
		rd(REG_DEVIATION, 32'h2f);
		rd(REG_STATUS, 32'h12);
		rd(8'h18, 32'h0);
		chk(tone_o, 1'b0);
		wb(1'b1, REG_CARRIER, 32'd20);
		rd(REG_CARRIER, 32'd20);
		key <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk(key_o, 1'b1);
		chk(rx_en_o, 1'b0);
		tone_run(2);
		tone_run(7);
		repeat (2) @(posedge clk_i);
		chk(key_o, 1'b0);
		repeat (RXD - 3) @(posedge clk_i);
		chk(rx_en_o, 1'b0);
		repeat (4) @(posedge clk_i);
		chk(rx_en_o, 1'b1);
		chk(tone_o, 1'b0);
		// Timed key-down is refused outside auto mode
		wb(1'b1, REG_AUTO_KEY, 32'd40);
		repeat (5) @(posedge clk_i);
		chk(key_o, 1'b0);
		rd(REG_STATUS, 32'h12);
		wb(1'b1, REG_CTRL, 32'h3);
		wb(1'b1, REG_AUTO_KEY, 32'd40);
		{cnt, t0} = 0;
		repeat (100) begin
			@(posedge clk_i);
			cnt += key_o;
			t0 += key_o & rx_en_o;
		end
		chk(cnt, 40);
		chk(t0, 0);
		chk(lcd_d_o, 4'h8);
		// Second write lands while busy and must be dropped
		t0 = $time;
		wb(1'b1, REG_DISPLAY, 32'h1a5);
		wb(1'b1, REG_DISPLAY, 32'h03c);
		cnt = 0;
		do begin
			wb(1'b0, REG_STATUS, 32'h0);
			chk(q[STAT_RX_BIT:STAT_KEY_BIT], 2'h2);
			cnt++;
		end while (q[STAT_DISP_BUSY_BIT] !== 1'b0 && cnt < 200);
		if (cnt >= 200) begin
			chk(32'h1, 32'h0);
			end_of_test();
		end
		chk(($time - t0) < 5000, 1'b1);
		chk(m_nib, 8'h2);
		chk(m_byte, 8'ha5);
		chk(m_rs, 1'b1);
		chk(lcd_d_o, 4'h8);
		wb(1'b1, REG_CTRL, 32'h1);
		repeat (2) @(posedge clk_i);
		chk(lcd_d_o, 4'h0);
		end_of_test();
	end
endmodule
